//--- core/hv_measure_routing_control.sv
/*
 High-voltage measurement routing control: register file, chip mode sequencing, pin gating and switch.
 Assumes AXI4-Lite software access, asynchronous pin inputs and same-clock supervisor inputs.
*/
`timescale 1ns/1ns
`include "hv_measure_map.svh"
module hv_measure_routing_control
	import hv_measure_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire axilReq_t axilReq,
	output axilRsp_t axilRsp,
	input wire logic hvWakeSensePin,
	input wire logic multiPinIn,
	output logic multiPinOut,
	output logic multiPinDrvN,
	input wire logic otherWakeSrc,
	input wire logic otherWakeEvt,
	input wire logic failSafeReq,
	output logic measureSwitch,
	output logic hvPullUp,
	output logic hvPullDown,
	output logic multiPullUp,
	output logic multiPullDown,
	output logic hvWakeSourceActive,
	output chipMode_t chipMode
);
	logic rstSync1_r, rstN;
	logic wrEn, wrOk, rdOk;
	logic [31:0] wrAddr, wrData, rdAddr, rdData;
	logic [3:0] wrStrb;
	logic [1:0] pinLvl, pinLvlDly_r;
	logic measureRouteEnable_r, fault_r, faultSet, faultClr;
	logic [4:0] wakeCfg_r;
	logic [4:0] pinFunc_r;
	logic [1:0] wakeStat_r, wakeLevel_r, wakeHit;
	chipMode_t mode_r, modeNxt;
	logic wrLow, wrCtrl, wrWake, wrFunc, wrMode, wrStat, wrWStat;
	logic sleepCmd, pinsOnlyWake, hvWakeOn, multiWakeOn;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstSync1_r <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstSync1_r <= 1'b1;
			rstN <= rstSync1_r;
		end
	end

	axil_slave uBus (
		.core_clk(core_clk),
		.rstN(rstN),
		.req(axilReq),
		.rsp(axilRsp),
		.wrEn(wrEn),
		.wrAddr(wrAddr),
		.wrData(wrData),
		.wrStrb(wrStrb),
		.wrOk(wrOk),
		.rdAddr(rdAddr),
		.rdData(rdData),
		.rdOk(rdOk)
	);

	pin_sync #(.WIDTH(2)) uSync (
		.core_clk(core_clk),
		.rstN(rstN),
		.pinIn({multiPinIn, hvWakeSensePin}),
		.pinOut(pinLvl)
	);

	// Write decode; all fields sit in byte lane zero
	assign wrLow = wrEn && wrStrb[0];
	assign wrCtrl = wrLow && (wrAddr == `OFF_CTRL);
	assign wrWake = wrLow && (wrAddr == `OFF_WAKE_CFG);
	assign wrFunc = wrLow && (wrAddr == `OFF_PIN_FUNC);
	assign wrMode = wrLow && (wrAddr == `OFF_MODE_CMD);
	assign wrStat = wrLow && (wrAddr == `OFF_STATUS);
	assign wrWStat = wrLow && (wrAddr == `OFF_WAKE_STAT);
	assign wrOk = (wrAddr == `OFF_CTRL) || (wrAddr == `OFF_WAKE_CFG) || (wrAddr == `OFF_PIN_FUNC) ||
		(wrAddr == `OFF_MODE_CMD) || (wrAddr == `OFF_STATUS) || (wrAddr == `OFF_WAKE_STAT);

	// Wake sources as configured; the fail-safe takeover only applies with routing off
	assign hvWakeOn = (wakeCfg_r[`BIT_HV_WAKE_EN] || (mode_r == MODE_FAILSAFE)) && !measureRouteEnable_r;
	assign multiWakeOn = (pinFunc_r[2:0] == `FUNC_WAKE) && !measureRouteEnable_r;
	assign pinsOnlyWake = (wakeCfg_r[`BIT_HV_WAKE_EN] || (pinFunc_r[2:0] == `FUNC_WAKE)) && !otherWakeSrc;
	assign sleepCmd = wrMode && (wrData[2:0] == `CMD_SLEEP) && (mode_r == MODE_NORMAL);

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			measureRouteEnable_r <= 1'b0;
		end else if (wrCtrl) begin
			if (!wrData[`BIT_MEAS_EN]) begin
				measureRouteEnable_r <= 1'b0;
			end else if (pinFunc_r[2:0] == `FUNC_OFF) begin
				measureRouteEnable_r <= 1'b1;
			end
		end
	end

	// Writes always land; the gating below decides whether they act
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			wakeCfg_r <= `RST_WAKE_CFG;
			pinFunc_r <= {2'h0, `RST_PIN_FUNC};
		end else begin
			if (wrWake) begin
				wakeCfg_r <= wrData[4:0];
			end
			if (wrFunc) begin
				pinFunc_r <= wrData[4:0];
			end
		end
	end

	assign faultSet = (wrCtrl && wrData[`BIT_MEAS_EN] && !measureRouteEnable_r &&
		(pinFunc_r[2:0] != `FUNC_OFF)) ||
		(wrFunc && measureRouteEnable_r && (wrData[4:0] != pinFunc_r)) ||
		(sleepCmd && measureRouteEnable_r && pinsOnlyWake);
	assign faultClr = wrStat && wrData[`BIT_FAULT];

	// Set wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= (fault_r && !faultClr) || faultSet;
		end
	end

	always_comb begin
		modeNxt = mode_r;
		unique case (mode_r)
			MODE_NORMAL, MODE_STOP: begin
				if (wrMode && (wrData[2:0] == `CMD_NORMAL)) begin
					modeNxt = MODE_NORMAL;
				end else if (wrMode && (wrData[2:0] == `CMD_STOP)) begin
					modeNxt = MODE_STOP;
				end else if (sleepCmd) begin
					modeNxt = (measureRouteEnable_r && pinsOnlyWake) ? MODE_RESTART : MODE_SLEEP;
				end
			end
			MODE_SLEEP: begin
				if ((|wakeHit) || otherWakeEvt) begin
					modeNxt = MODE_RESTART;
				end
			end
			MODE_RESTART: begin
				modeNxt = MODE_NORMAL;
			end
			MODE_FAILSAFE: begin
				if (!failSafeReq) begin
					modeNxt = MODE_RESTART;
				end
			end
			default: begin
				modeNxt = MODE_RESTART;
			end
		endcase
		if (failSafeReq) begin
			modeNxt = MODE_FAILSAFE;
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			mode_r <= MODE_NORMAL;
		end else begin
			mode_r <= modeNxt;
		end
	end
	assign chipMode = mode_r;

	// Rising edges wake; nothing is seen from the pins while routing is on
	assign wakeHit = {multiWakeOn, hvWakeOn} & pinLvl & ~pinLvlDly_r;

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			pinLvlDly_r <= 2'h0;
			wakeStat_r <= 2'h0;
			wakeLevel_r <= 2'h0;
		end else begin
			pinLvlDly_r <= pinLvl;
			wakeStat_r <= (wakeStat_r & ~({2{wrWStat}} & wrData[1:0])) | wakeHit;
			if (!measureRouteEnable_r) begin
				wakeLevel_r <= pinLvl;
			end
		end
	end

	// Pin drive, pulls and switch; registered so the pads see no decode glitches
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			measureSwitch <= 1'b0;
			hvPullUp <= 1'b0;
			hvPullDown <= 1'b0;
			multiPullUp <= 1'b0;
			multiPullDown <= 1'b0;
			multiPinOut <= 1'b1;
			multiPinDrvN <= 1'b1;
			hvWakeSourceActive <= 1'b0;
		end else begin
			measureSwitch <= measureRouteEnable_r && (mode_r == MODE_NORMAL);
			hvPullUp <= !measureRouteEnable_r && (wakeCfg_r[1:0] == `PULL_UP);
			hvPullDown <= !measureRouteEnable_r && (wakeCfg_r[1:0] == `PULL_DOWN);
			multiPullUp <= !measureRouteEnable_r && (wakeCfg_r[3:2] == `PULL_UP);
			multiPullDown <= !measureRouteEnable_r && (wakeCfg_r[3:2] == `PULL_DOWN);
			hvWakeSourceActive <= hvWakeOn;
			multiPinOut <= 1'b1;
			multiPinDrvN <= 1'b1;
			if (!measureRouteEnable_r) begin
				unique case (pinFunc_r[2:0])
					`FUNC_FAIL_OUT: begin
						multiPinOut <= 1'b0;
						multiPinDrvN <= !((mode_r == MODE_FAILSAFE) || pinFunc_r[`BIT_FO_TEST]);
					end
					`FUNC_LOW_SIDE: begin
						multiPinOut <= 1'b0;
						multiPinDrvN <= !pinFunc_r[`BIT_GP_LEVEL];
					end
					`FUNC_HIGH_SIDE: begin
						multiPinOut <= 1'b1;
						multiPinDrvN <= !pinFunc_r[`BIT_GP_LEVEL];
					end
					default: begin
						multiPinDrvN <= 1'b1;
					end
				endcase
			end
		end
	end

	always_comb begin
		rdOk = 1'b1;
		rdData = 32'h0000_0000;
		unique case (rdAddr)
			`OFF_CTRL: rdData[`BIT_MEAS_EN] = measureRouteEnable_r;
			`OFF_WAKE_CFG: rdData[4:0] = wakeCfg_r;
			`OFF_PIN_FUNC: rdData[4:0] = pinFunc_r;
			`OFF_MODE_CMD: rdData[2:0] = mode_r;
			`OFF_STATUS: rdData[1:0] = {measureSwitch, fault_r};
			`OFF_WAKE_STAT: rdData[3:0] = {wakeLevel_r, wakeStat_r};
			default: rdOk = 1'b0;
		endcase
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstN);

	switch_normal_a: assert property (measureSwitch == $past(measureRouteEnable_r && mode_r == MODE_NORMAL))
		else $error("switch does not follow enable in normal mode");
	switch_open_a: assert property (mode_r != MODE_NORMAL |=> !measureSwitch)
		else $error("switch closed outside normal mode");
	enable_kept_a: assert property (measureRouteEnable_r && failSafeReq && !wrCtrl |=> measureRouteEnable_r)
		else $error("enable lost on fail-safe entry");
	pulls_off_a: assert property (measureRouteEnable_r |=> !(hvPullUp || hvPullDown || multiPullUp || multiPullDown))
		else $error("pull current on while routing");
	level_frozen_a: assert property (measureRouteEnable_r |=> $stable(wakeLevel_r) && (wakeStat_r & ~$past(wakeStat_r)) == 2'h0)
		else $error("status updated while routing");
	pin_quiet_a: assert property (measureRouteEnable_r |=> multiPinDrvN)
		else $error("multi pin driven while routing");
	func_fault_a: assert property (wrFunc && measureRouteEnable_r && wrData[4:0] != pinFunc_r |=> fault_r)
		else $error("function change while routing did not fault");
	enable_refused_a: assert property (wrCtrl && wrData[`BIT_MEAS_EN] && !measureRouteEnable_r &&
		pinFunc_r[2:0] != `FUNC_OFF
		|=> !measureRouteEnable_r && fault_r)
		else $error("enable accepted with multi pin in use");
	sleep_refused_a: assert property (sleepCmd && measureRouteEnable_r && pinsOnlyWake && !failSafeReq
		|=> mode_r == MODE_RESTART && fault_r ##1 mode_r == MODE_NORMAL)
		else $error("sleep not refused");
	failsafe_wake_a: assert property (mode_r == MODE_FAILSAFE && !measureRouteEnable_r |=> hvWakeSourceActive)
		else $error("sense pin not a wake source in fail-safe");
	fault_sticky_a: assert property (fault_r && !faultClr |=> fault_r)
		else $error("fault dropped without clear");
endmodule

//--- core/hv_measure_map.svh
/*
 Register offsets, field positions, reset values and codes of the measurement routing block.
 Assumes inclusion by the main module and the test bench only.
*/
`ifndef HV_MEASURE_MAP_SVH
`define HV_MEASURE_MAP_SVH
`define OFF_CTRL 32'h0000_0000
`define OFF_WAKE_CFG 32'h0000_0004
`define OFF_PIN_FUNC 32'h0000_0008
`define OFF_MODE_CMD 32'h0000_000c
`define OFF_STATUS 32'h0000_0010
`define OFF_WAKE_STAT 32'h0000_0014
`define BIT_MEAS_EN 0
`define BIT_FAULT 0
`define BIT_SWITCH 1
`define BIT_FO_TEST 3
`define BIT_GP_LEVEL 4
`define BIT_HV_WAKE_EN 4
`define FUNC_OFF 3'h0
`define FUNC_FAIL_OUT 3'h1
`define FUNC_WAKE 3'h2
`define FUNC_LOW_SIDE 3'h3
`define FUNC_HIGH_SIDE 3'h4
`define RST_PIN_FUNC 3'h1
`define RST_WAKE_CFG 5'h00
`define PULL_DOWN 2'h1
`define PULL_UP 2'h2
`define CMD_NORMAL 3'h0
`define CMD_STOP 3'h1
`define CMD_SLEEP 3'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

//--- core/hv_measure_pkg.sv
/*
 Types shared by the measurement routing block: chip modes and AXI4-Lite carriers.
 Assumes a 32-bit AXI4-Lite bus.
*/
package hv_measure_pkg;
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'b000,
		MODE_STOP = 3'b001,
		MODE_SLEEP = 3'b010,
		MODE_RESTART = 3'b011,
		MODE_FAILSAFE = 3'b100
	} chipMode_t;

	typedef struct packed {
		logic awvalid;
		logic [31:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [31:0] araddr;
		logic rready;
	} axilReq_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axilRsp_t;
endpackage

//--- core/pin_sync.sv
/*
 Three-stage synchroniser for pin inputs; a change counts once stages two and three agree.
 Assumes inputs asynchronous to core_clk and a reset already synchronised.
*/
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 2
) (
	input wire logic core_clk,
	input wire logic rstN,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : gBit
			logic s1_r, s2_r, s3_r, q_r;
			always_ff @(posedge core_clk or negedge rstN) begin
				if (!rstN) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
					s3_r <= 1'b0;
				end else begin
					s1_r <= pinIn[i];
					s2_r <= s1_r;
					s3_r <= s2_r;
				end
			end
			// Stage one feeds only stage two; filter looks at two and three
			always_ff @(posedge core_clk or negedge rstN) begin
				if (!rstN) begin
					q_r <= 1'b0;
				end else if (s2_r == s3_r) begin
					q_r <= s3_r;
				end
			end
			assign pinOut[i] = q_r;
		end
	endgenerate
endmodule

//--- core/axil_slave.sv
/*
 AXI4-Lite slave front end: takes address and data in either order, one write and one read at a time.
 Assumes the register file decodes combinationally and reports whether an address is mapped.
*/
`timescale 1ns/1ns
module axil_slave
	import hv_measure_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstN,
	input wire axilReq_t req,
	output axilRsp_t rsp,
	output logic wrEn,
	output logic [31:0] wrAddr,
	output logic [31:0] wrData,
	output logic [3:0] wrStrb,
	input wire logic wrOk,
	output logic [31:0] rdAddr,
	input wire logic [31:0] rdData,
	input wire logic rdOk
);
	logic awHave_r, wHave_r, bValid_r, rValid_r;
	logic [1:0] bResp_r, rResp_r;
	logic [31:0] rData_r;

	// Address and data are refused while a response waits, so one write is in flight
	assign rsp.awready = !awHave_r && !bValid_r;
	assign rsp.wready = !wHave_r && !bValid_r;
	assign rsp.arready = !rValid_r;
	assign rsp.bvalid = bValid_r;
	assign rsp.bresp = bResp_r;
	assign rsp.rvalid = rValid_r;
	assign rsp.rdata = rData_r;
	assign rsp.rresp = rResp_r;
	assign wrEn = awHave_r && wHave_r;
	assign rdAddr = req.araddr;

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			awHave_r <= 1'b0;
			wHave_r <= 1'b0;
			bValid_r <= 1'b0;
			bResp_r <= `RESP_OKAY;
			wrAddr <= 32'h0000_0000;
			wrData <= 32'h0000_0000;
			wrStrb <= 4'h0;
		end else begin
			if (req.awvalid && rsp.awready) begin
				awHave_r <= 1'b1;
				wrAddr <= req.awaddr;
			end
			if (req.wvalid && rsp.wready) begin
				wHave_r <= 1'b1;
				wrData <= req.wdata;
				wrStrb <= req.wstrb;
			end
			if (wrEn) begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				bValid_r <= 1'b1;
				bResp_r <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
			end else if (bValid_r && req.bready) begin
				bValid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			rValid_r <= 1'b0;
			rData_r <= 32'h0000_0000;
			rResp_r <= `RESP_OKAY;
		end else if (req.arvalid && rsp.arready) begin
			rValid_r <= 1'b1;
			rData_r <= rdOk ? rdData : 32'h0000_0000;
			rResp_r <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
		end else if (rValid_r && req.rready) begin
			rValid_r <= 1'b0;
		end
	end
endmodule

//--- verif/axil_host.sv
/*
 Host model: AXI4-Lite master with one write task and one read task.
 Assumes a slave on core_clk that answers whenever its own logic allows.
*/
`timescale 1ns/1ns
module axil_host
	import hv_measure_pkg::*;
(
	input wire logic core_clk,
	output axilReq_t req,
	input wire axilRsp_t rsp
);
	initial req = '0;

	// Address and data go out together; each is dropped at the edge that takes it.
	// Ready and valid are read on the falling edge, where they are settled, to avoid an edge race.
	task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
		logic awOk, wOk, awDone, wDone, bOk;
		awDone = 1'b0;
		wDone = 1'b0;
		@(posedge core_clk);
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		do begin
			@(negedge core_clk);
			awOk = rsp.awready;
			wOk = rsp.wready;
			@(posedge core_clk);
			if (awOk && !awDone) begin
				req.awvalid <= 1'b0;
				awDone = 1'b1;
			end
			if (wOk && !wDone) begin
				req.wvalid <= 1'b0;
				wDone = 1'b1;
			end
		end while (!(awDone && wDone));
		do begin
			@(negedge core_clk);
			bOk = rsp.bvalid;
			r = rsp.bresp;
			@(posedge core_clk);
		end while (!bOk);
		req.bready <= 1'b0;
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
		logic arOk, rOk;
		@(posedge core_clk);
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		do begin
			@(negedge core_clk);
			arOk = rsp.arready;
			@(posedge core_clk);
		end while (!arOk);
		req.arvalid <= 1'b0;
		do begin
			@(negedge core_clk);
			rOk = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge core_clk);
		end while (!rOk);
		req.rready <= 1'b0;
	endtask
endmodule

//--- verif/hv_measure_routing_control_test.sv
/*
 Self-checking bench for the measurement routing control block.
 Assumes the host model drives the register bus; pins and supervisor inputs come from here.
*/
`timescale 1ns/1ns
`include "hv_measure_map.svh"
module hv_measure_routing_control_test
	import hv_measure_pkg::*;
;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic hvWakeSensePin = 1'b0;
	logic multiExt = 1'b0;
	logic failSafeReq = 1'b0;
	axilReq_t axilReq;
	axilRsp_t axilRsp;
	logic multiPinIn, multiPinOut, multiPinDrvN, measureSwitch, hvWakeSourceActive;
	logic hvPullUp, hvPullDown, multiPullUp, multiPullDown;
	chipMode_t chipMode;
	int errCount = 0;
	int cmpCount = 0;
	int restartCnt = 0;
	int n;
	logic [31:0] rdv, lvl;
	logic [1:0] resp;

	// Multi pin wire: the block wins while it drives, else the outside level
	assign multiPinIn = multiPinDrvN ? multiExt : multiPinOut;
	initial forever #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (chipMode === MODE_RESTART) restartCnt <= restartCnt + 1;

	hv_measure_routing_control dut (.core_clk(core_clk), .arst_n(arst_n), .axilReq(axilReq),
		.axilRsp(axilRsp), .hvWakeSensePin(hvWakeSensePin), .multiPinIn(multiPinIn),
		.multiPinOut(multiPinOut), .multiPinDrvN(multiPinDrvN), .otherWakeSrc(1'b0),
		.otherWakeEvt(1'b0), .failSafeReq(failSafeReq), .measureSwitch(measureSwitch),
		.hvPullUp(hvPullUp), .hvPullDown(hvPullDown), .multiPullUp(multiPullUp),
		.multiPullDown(multiPullDown), .hvWakeSourceActive(hvWakeSourceActive), .chipMode(chipMode));
	axil_host host (.core_clk(core_clk), .req(axilReq), .rsp(axilRsp));

	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		cmpCount++;
		if (got !== exp) begin
			errCount++;
			$display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic w(input logic [31:0] a, input logic [31:0] d);
		host.wr(a, d, resp);
		chk(resp, `RESP_OKAY);
	endtask
	task automatic r(input logic [31:0] a, input logic [31:0] exp);
		host.rd(a, rdv, resp);
		chk({resp, rdv}, {`RESP_OKAY, exp});
	endtask
	task automatic fsafe(input chipMode_t m, input logic [1:0] swWake);
		@(posedge core_clk) failSafeReq <= 1'b1;
		wt(3);
		chk({chipMode, measureSwitch, hvWakeSourceActive}, {m, swWake});
		@(posedge core_clk) failSafeReq <= 1'b0;
		wt(4);
		chk(chipMode, MODE_NORMAL);
	endtask
	task automatic printVerdict();
		$display("errors %0d compares %0d", errCount, cmpCount);
		if (errCount == 0 && cmpCount > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	initial begin
		#40000;
		errCount++;
		printVerdict();
	end

	initial begin
		lvl = $urandom(32'hb09d32ea);
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		wt(3);
		chk({measureSwitch, hvPullUp, hvPullDown, multiPullUp, multiPullDown, multiPinDrvN}, 6'h01);
		chk(chipMode, MODE_NORMAL);
		r(`OFF_CTRL, 0);
		r(`OFF_PIN_FUNC, `RST_PIN_FUNC);
		host.rd(32'h40, rdv, resp);
		chk({resp, rdv}, {`RESP_SLVERR, 32'h0});
		w(`OFF_CTRL, 1);
		r(`OFF_CTRL, 0);
		r(`OFF_STATUS, 1);
		w(`OFF_STATUS, 1);
		r(`OFF_STATUS, 0);
		w(`OFF_WAKE_CFG, 32'h06);
		lvl = $urandom % 2;
		@(posedge core_clk) hvWakeSensePin <= lvl[0];
		wt(8);
		chk({hvPullUp, hvPullDown, multiPullUp, multiPullDown}, 4'b1001);
		host.rd(`OFF_WAKE_STAT, rdv, resp);
		chk(rdv[3:2], {1'b0, lvl[0]});
		w(`OFF_PIN_FUNC, 32'h09);
		wt(2);
		chk({multiPinDrvN, multiPinOut}, 2'b00);
		fsafe(MODE_FAILSAFE, 2'b01);
		w(`OFF_PIN_FUNC, 0);
		w(`OFF_CTRL, 1);
		wt(2);
		chk({measureSwitch, hvPullUp, hvPullDown, multiPullUp, multiPullDown, multiPinDrvN}, 6'h21);
		r(`OFF_CTRL, 1);
		r(`OFF_STATUS, 2);
		w(`OFF_WAKE_CFG, 32'h1a);
		r(`OFF_WAKE_CFG, 32'h1a);
		w(`OFF_WAKE_STAT, 3);
		@(posedge core_clk) hvWakeSensePin <= ~lvl[0];
		multiExt <= 1'b1;
		wt(8);
		chk({hvPullUp, hvPullDown, multiPullUp, multiPullDown}, 4'b0000);
		r(`OFF_WAKE_STAT, lvl << 2);
		w(`OFF_PIN_FUNC, 32'h09);
		wt(2);
		chk(multiPinDrvN, 1'b1);
		r(`OFF_STATUS, 3);
		w(`OFF_PIN_FUNC, 0);
		w(`OFF_STATUS, 1);
		r(`OFF_STATUS, 2);
		w(`OFF_MODE_CMD, `CMD_STOP);
		wt(2);
		chk({chipMode, measureSwitch}, {MODE_STOP, 1'b0});
		r(`OFF_CTRL, 1);
		w(`OFF_MODE_CMD, `CMD_NORMAL);
		wt(2);
		chk(measureSwitch, 1'b1);
		n = restartCnt;
		w(`OFF_MODE_CMD, `CMD_SLEEP);
		wt(3);
		chk({chipMode, 32'(restartCnt - n)}, {MODE_NORMAL, 32'h1});
		r(`OFF_STATUS, 3);
		w(`OFF_STATUS, 1);
		fsafe(MODE_FAILSAFE, 2'b00);
		r(`OFF_CTRL, 1);
		w(`OFF_CTRL, 0);
		wt(2);
		chk({measureSwitch, hvPullUp, hvPullDown, multiPullUp, multiPullDown}, 5'b01010);
		chk(hvWakeSourceActive, 1'b1);
		@(posedge core_clk) hvWakeSensePin <= 1'b0;
		wt(8);
		w(`OFF_WAKE_STAT, 3);
		@(posedge core_clk) hvWakeSensePin <= 1'b1;
		wt(8);
		r(`OFF_WAKE_STAT, 32'hd);
		w(`OFF_PIN_FUNC, 32'h14);
		wt(2);
		chk({multiPinDrvN, multiPinOut}, 2'b01);
		printVerdict();
	end
endmodule
